// ===== src/lbrg_cpu_end.sv
// processor end of the request/grant link: arbitration, grant and reclaim
`timescale 1ns/1ns
`default_nettype none
`include "lbrg_regs.svh"
module lbrg_cpu_end (
	input wire logic clk,
	input wire logic sys_rst,
	lbrg_if.cpu link,
	input wire lbrg_pkg::lbrg_cyc_t cur_cycle, // kind of bus cycle running
	input wire lbrg_pkg::lbrg_bstate_t cur_bstate, // bus state of that cycle
	input wire logic cycle_end, // last clock of the running cycle
	input wire logic odd_low_byte, // running cycle is low byte at odd address
	input wire logic lock_active, // locked instruction executing
	input wire logic cycle_pending, // a bus cycle waits to run
	output logic bus_float, // local bus outputs floated
	output logic cycle_start_ok, // bus unit may start a new cycle
	output logic reclaim_final, // pulses when bus retaken into final state
	output logic reclaim_idle, // pulses when bus retaken into idle state
	output logic grant_ch // channel being served, 1 = low priority
);
	// exchange states; the echo state waits out the grant pulse coming back
	typedef enum logic [2:0] {
		ST_IDLE, // line at rest, bus owned by the processor
		ST_WAIT, // request taken, waiting for a cycle that may release
		ST_GRANT_PULSE, // grant pulse on the served line
		ST_ECHO, // own grant pulse still in the synchroniser
		ST_HOLD, // bus handed over, waiting for the release pulse
		ST_RECLAIM, // release seen, bus taken back
		ST_GAP // idle clock between exchanges
	} lbrg_cst_t;
	lbrg_cst_t st_r, st_nxt;
	logic ch_r, ch_nxt; // served channel
	logic early_r, early_nxt; // request seen by state two
	logic [1:0] late_r, late_nxt; // clocks since request on idle bus
	logic fin_r, fin_nxt; // reclaim into final state
	logic idl_r, idl_nxt; // reclaim into idle state
	logic [1:0] gap_r, gap_nxt; // idle clocks still owed after an exchange
	logic s0a_r, s0b_r, s1a_r, s1b_r, p0_r, p1_r; // synchronisers and delay
	logic lvl0, lvl1, fall0, fall1, ch_fall;

	// two-flop synchronisers on both lines, then one delay for edge detect
	// the two flops cost two clocks before a pulse is seen; traded for clean levels
	// both ends add the same latency, so the pulses stay in step
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s0a_r <= `LBRG_LINE_REST;
			s0b_r <= `LBRG_LINE_REST;
			s1a_r <= `LBRG_LINE_REST;
			s1b_r <= `LBRG_LINE_REST;
			p0_r <= `LBRG_LINE_REST;
			p1_r <= `LBRG_LINE_REST;
		end else begin
			s0a_r <= link.bus_handoff_line_high_prio;
			s0b_r <= s0a_r;
			s1a_r <= link.bus_handoff_line_low_prio;
			s1b_r <= s1a_r;
			p0_r <= s0b_r;
			p1_r <= s1b_r;
		end
	end

	// synchronised levels of both lines
	assign lvl0 = s0b_r;
	assign lvl1 = s1b_r;
	// falling edge marks a pulse start; the pulse is one clock wide
	// a pulse also comes back from this end's own grant, see the echo state
	assign fall0 = p0_r && (lvl0 == `LBRG_LINE_ACTIVE);
	assign fall1 = p1_r && (lvl1 == `LBRG_LINE_ACTIVE);
	// only the served channel can end a hold
	assign ch_fall = ch_r ? fall1 : fall0;

	// release is allowed at once on an idle bus, otherwise only at the end of a cycle that qualifies
	// a memory cycle also needs an early request, an even byte and no lock
	// input and output cycles, and the second acknowledge, release at their end on an even byte
	function automatic logic may_release(input lbrg_pkg::lbrg_cyc_t c, input logic early,
		input logic endc, input logic odd, input logic lck);
		may_release = 1'b0;
		case (c)
			lbrg_pkg::LBRG_CYC_NONE: may_release = 1'b1;
			lbrg_pkg::LBRG_CYC_INTA1: may_release = 1'b0;
			lbrg_pkg::LBRG_CYC_MEM: may_release = endc && early && !odd && !lck;
			default: may_release = endc && !odd;
		endcase
	endfunction : may_release

	// next-state logic of the exchange
	// only one exchange runs at a time; a request seen while busy is dropped,
	// which the idle-clock rule between exchanges makes safe
	always_comb begin
		st_nxt = st_r;
		ch_nxt = ch_r;
		early_nxt = early_r;
		late_nxt = late_r;
		fin_nxt = 1'b0;
		idl_nxt = 1'b0;
		gap_nxt = gap_r;
		case (st_r)
			ST_IDLE: begin
				// a tie goes to the high-priority channel
				if (fall0 || fall1) begin
					ch_nxt = fall0 ? 1'b0 : 1'b1;
					st_nxt = ST_WAIT;
					// request by state two, or on an idle bus, counts as early
					early_nxt = (cur_bstate != lbrg_pkg::LBRG_BS_LATE);
					late_nxt = 2'h0;
				end
			end
			// count clocks since the request, stopping at three
			ST_WAIT: begin
				if (late_r != 2'h3) begin
					late_nxt = late_r + 2'h1;
				end
				// an idle bus three or more clocks after the request sets the early mark
				if (cur_cycle == lbrg_pkg::LBRG_CYC_NONE && late_r >= 2'(`LBRG_LATE_START_CYC)) begin
					early_nxt = 1'b1;
				end
				// the bus is handed over only where the cycle rules allow it
				if (may_release(cur_cycle, early_r, cycle_end, odd_low_byte, lock_active)) begin
					st_nxt = ST_GRANT_PULSE;
				end
			end
			ST_GRANT_PULSE: st_nxt = ST_ECHO;
			// the grant pulse comes back through the synchroniser and must
			// not be taken for the release pulse
			ST_ECHO: begin
				if (ch_fall) begin
					st_nxt = ST_HOLD;
				end
			end
			// the master alone ends the hold
			ST_HOLD: begin
				if (ch_fall) begin
					st_nxt = ST_RECLAIM;
				end
			end
			// final state if a cycle waits, idle state otherwise
			ST_RECLAIM: begin
				fin_nxt = cycle_pending;
				idl_nxt = !cycle_pending;
				gap_nxt = 2'(`LBRG_IDLE_GAP_CYC);
				st_nxt = ST_GAP;
			end
			// a request whose start falls in the gap is not taken
			ST_GAP: begin
				if (gap_r > 2'h1) begin
					gap_nxt = gap_r - 2'h1;
				end else begin
					st_nxt = ST_IDLE;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	// state registers
	// every register of the exchange loads on each clock; reset parks the line at rest
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= ST_IDLE;
			ch_r <= 1'b0;
			early_r <= 1'b0;
			late_r <= 2'h0;
			fin_r <= 1'b0;
			idl_r <= 1'b0;
			gap_r <= 2'h0;
		end else begin
			st_r <= st_nxt;
			ch_r <= ch_nxt;
			early_r <= early_nxt;
			late_r <= late_nxt;
			fin_r <= fin_nxt;
			idl_r <= idl_nxt;
			gap_r <= gap_nxt;
		end
	end

	// grant pulse driven low on the served line only, one clock wide
	// the output level is fixed; only the enable moves, as on an open-drain pin
	assign link.cpu_o0 = `LBRG_LINE_ACTIVE;
	assign link.cpu_o1 = `LBRG_LINE_ACTIVE;
	assign link.cpu_oe0 = (st_r == ST_GRANT_PULSE) && !ch_r;
	assign link.cpu_oe1 = (st_r == ST_GRANT_PULSE) && ch_r;
	// bus floats from the grant pulse until reclaimed, the echo wait included
	assign bus_float = (st_r == ST_GRANT_PULSE) || (st_r == ST_ECHO)
		|| (st_r == ST_HOLD);
	// waiting for release also holds off new cycles so the bus can be handed over
	assign cycle_start_ok = (st_r == ST_IDLE) || (st_r == ST_GAP) || (st_r == ST_RECLAIM);
	// reclaim pulses and served channel come straight from flip-flops
	assign reclaim_final = fin_r;
	assign reclaim_idle = idl_r;
	assign grant_ch = ch_r;
	// lvl1 seen only through fall1; unconnected low line reads rest by pull-up
endmodule : lbrg_cpu_end
`default_nettype wire

// ===== src/lbrg_regs.svh
// timing and encoding constants for the local bus request/grant link
`ifndef LBRG_REGS_SVH
`define LBRG_REGS_SVH
`define LBRG_PULSE_NS 40
`define LBRG_CLK_NS 40
`define LBRG_PULSE_CYC ((`LBRG_PULSE_NS + `LBRG_CLK_NS - 1) / `LBRG_CLK_NS)
`define LBRG_IDLE_GAP_CYC 1
`define LBRG_LATE_START_CYC 3
`define LBRG_LINE_ACTIVE 1'b0
`define LBRG_LINE_REST 1'b1
`endif

// ===== src/lbrg_pkg.sv
// shared types for the local bus request/grant link
package lbrg_pkg;
	typedef enum logic [2:0] {
		LBRG_CYC_NONE,
		LBRG_CYC_MEM,
		LBRG_CYC_IO,
		LBRG_CYC_INTA1,
		LBRG_CYC_INTA2
	} lbrg_cyc_t;
	typedef enum logic [1:0] {
		LBRG_BS_IDLE,
		LBRG_BS_T1,
		LBRG_BS_T2,
		LBRG_BS_LATE
	} lbrg_bstate_t;
endpackage : lbrg_pkg

// ===== src/lbrg_if.sv
// two request/grant lines shared by the processor and an external master
`timescale 1ns/1ns
`default_nettype none
interface lbrg_if;
	logic cpu_oe0; // processor drives high-priority line low
	logic cpu_oe1;
	logic mst_oe0; // external master drives high-priority line low
	logic mst_oe1;
	logic cpu_o0;
	logic cpu_o1;
	logic mst_o0;
	logic mst_o1;
	logic bus_handoff_line_high_prio; // resolved wire level
	logic bus_handoff_line_low_prio;
	// open-drain style resolution; both lines have pull-up hold
	assign bus_handoff_line_high_prio = !((cpu_oe0 && !cpu_o0) || (mst_oe0 && !mst_o0));
	assign bus_handoff_line_low_prio = !((cpu_oe1 && !cpu_o1) || (mst_oe1 && !mst_o1));
	modport cpu (
		input bus_handoff_line_high_prio,
		input bus_handoff_line_low_prio,
		output cpu_oe0,
		output cpu_oe1,
		output cpu_o0,
		output cpu_o1
	);
	modport master (
		input bus_handoff_line_high_prio,
		input bus_handoff_line_low_prio,
		output mst_oe0,
		output mst_oe1,
		output mst_o0,
		output mst_o1
	);
endinterface : lbrg_if
`default_nettype wire

// ===== src/lbrg_master_end.sv
// external master end: request, wait for grant, hold, release
`timescale 1ns/1ns
`default_nettype none
`include "lbrg_regs.svh"
module lbrg_master_end #(
	parameter logic USE_LOW = 1'b0 // 1 = use low-priority line
) (
	input wire logic clk,
	input wire logic sys_rst,
	lbrg_if.master link,
	input wire logic want_bus, // level: master wants the local bus
	output logic has_bus, // master owns the bus
	output logic busy // an exchange is in progress
);
	typedef enum logic [2:0] {
		MS_IDLE,
		MS_REQ,
		MS_ECHO,
		MS_WAIT,
		MS_OWN,
		MS_REL,
		MS_GAP
	} lbrg_mst_t;
	lbrg_mst_t st_r, st_nxt;
	logic sa_r, sb_r, p_r; // line synchroniser and delay
	logic line, fall;

	assign line = USE_LOW ? link.bus_handoff_line_low_prio : link.bus_handoff_line_high_prio;

	// synchronise the shared line before watching for the grant
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sa_r <= `LBRG_LINE_REST;
			sb_r <= `LBRG_LINE_REST;
			p_r <= `LBRG_LINE_REST;
		end else begin
			sa_r <= line;
			sb_r <= sa_r;
			p_r <= sb_r;
		end
	end
	assign fall = p_r && (sb_r == `LBRG_LINE_ACTIVE);

	// next state; the own request pulse comes back through the synchroniser
	// first and is swallowed in the echo state before the grant is awaited
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			MS_IDLE: if (want_bus) st_nxt = MS_REQ;
			MS_REQ: st_nxt = MS_ECHO;
			MS_ECHO: if (fall) st_nxt = MS_WAIT;
			MS_WAIT: if (fall) st_nxt = MS_OWN;
			MS_OWN: if (!want_bus) st_nxt = MS_REL;
			MS_REL: st_nxt = MS_GAP;
			MS_GAP: st_nxt = MS_IDLE;
			default: st_nxt = MS_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= MS_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// the own request pulse also reaches the synchroniser; a grant is only
	// accepted once that echo has been seen
	assign link.mst_o0 = `LBRG_LINE_ACTIVE;
	assign link.mst_o1 = `LBRG_LINE_ACTIVE;
	assign link.mst_oe0 = !USE_LOW && (st_r == MS_REQ || st_r == MS_REL);
	assign link.mst_oe1 = USE_LOW && (st_r == MS_REQ || st_r == MS_REL);
	assign has_bus = (st_r == MS_OWN);
	assign busy = (st_r != MS_IDLE);
endmodule : lbrg_master_end
`default_nettype wire

// ===== tb/lbrg_link_asserts.sv
// timing checks on the two shared request/grant lines
`timescale 1ns/1ns
`default_nettype none
module lbrg_link_asserts (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cpu_oe0,
	input wire logic cpu_oe1,
	input wire logic mst_oe0,
	input wire logic mst_oe1,
	input wire logic bus_handoff_line_high_prio,
	input wire logic bus_handoff_line_low_prio
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// master request starts on the high-priority line
	sequence s_req0;
		$rose(mst_oe0);
	endsequence
	// two sync flops plus detect keep the processor quiet this long
	sequence s_quiet0;
		!cpu_oe0 [*3];
	endsequence
	property p_grant0; $rose(cpu_oe0) |=> !cpu_oe0; endproperty
	property p_grant1; $rose(cpu_oe1) |=> !cpu_oe1; endproperty
	property p_req0; $rose(mst_oe0) |=> !mst_oe0; endproperty
	property p_req1; $rose(mst_oe1) |=> !mst_oe1; endproperty
	property p_own0; !(cpu_oe0 && mst_oe0); endproperty
	property p_own1; !(cpu_oe1 && mst_oe1); endproperty
	property p_rest0; !cpu_oe0 && !mst_oe0 |-> bus_handoff_line_high_prio; endproperty
	property p_prio; !(cpu_oe0 && cpu_oe1); endproperty
	property p_lat0; s_req0 |-> s_quiet0; endproperty
	a_grant0: assert property (p_grant0) else $error("grant pulse too long");
	a_grant1: assert property (p_grant1) else $error("grant pulse too long");
	a_req0: assert property (p_req0) else $error("request pulse too long");
	a_req1: assert property (p_req1) else $error("request pulse too long");
	a_own0: assert property (p_own0) else $error("both ends drive line");
	a_own1: assert property (p_own1) else $error("both ends drive line");
	a_rest0: assert property (p_rest0) else $error("undriven line not high");
	a_prio: assert property (p_prio) else $error("two grants at once");
	a_lat0: assert property (p_lat0) else $error("grant too early");
endmodule : lbrg_link_asserts
`default_nettype wire

// ===== tb/local_bus_request_grant_test.sv
// bench: processor end and master end joined on one link
`timescale 1ns/1ns
`default_nettype none
module local_bus_request_grant_test;
	typedef struct packed {
		lbrg_pkg::lbrg_cyc_t cyc; // running cycle kind
		lbrg_pkg::lbrg_bstate_t bs; // its bus state
		logic odd; // odd-address low byte
		logic lck; // locked instruction
		logic ok; // release expected
	} lbrg_row_t;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	lbrg_pkg::lbrg_cyc_t cur_cycle = lbrg_pkg::LBRG_CYC_NONE;
	lbrg_pkg::lbrg_bstate_t cur_bstate = lbrg_pkg::LBRG_BS_IDLE;
	logic cycle_end = 1'b1; // held: every clock ends a cycle
	logic odd_low_byte = 1'b0;
	logic lock_active = 1'b0;
	logic cycle_pending = 1'b0;
	logic want_bus = 1'b0;
	logic bus_float, cycle_start_ok, reclaim_final, reclaim_idle, grant_ch, has_bus, busy;
	int fail_count = 0;
	int n_checks = 0;
	int cyc_count = 0; // timeout ceiling counter
	// decision table: a refused row is later let through on an idle bus
	lbrg_row_t rows [7] = '{
		'{lbrg_pkg::LBRG_CYC_NONE, lbrg_pkg::LBRG_BS_IDLE, 1'b0, 1'b0, 1'b1},
		'{lbrg_pkg::LBRG_CYC_MEM, lbrg_pkg::LBRG_BS_T2, 1'b0, 1'b0, 1'b1},
		'{lbrg_pkg::LBRG_CYC_MEM, lbrg_pkg::LBRG_BS_LATE, 1'b0, 1'b0, 1'b0},
		'{lbrg_pkg::LBRG_CYC_MEM, lbrg_pkg::LBRG_BS_T2, 1'b1, 1'b0, 1'b0},
		'{lbrg_pkg::LBRG_CYC_MEM, lbrg_pkg::LBRG_BS_T1, 1'b0, 1'b1, 1'b0},
		'{lbrg_pkg::LBRG_CYC_INTA1, lbrg_pkg::LBRG_BS_T2, 1'b0, 1'b0, 1'b0},
		'{lbrg_pkg::LBRG_CYC_INTA2, lbrg_pkg::LBRG_BS_T1, 1'b0, 1'b0, 1'b1}};
	lbrg_if link();
	lbrg_cpu_end lbrg_cpu_end_inst (.clk(clk), .sys_rst(sys_rst), .link(link),
		.cur_cycle(cur_cycle), .cur_bstate(cur_bstate), .cycle_end(cycle_end),
		.odd_low_byte(odd_low_byte), .lock_active(lock_active),
		.cycle_pending(cycle_pending), .bus_float(bus_float),
		.cycle_start_ok(cycle_start_ok), .reclaim_final(reclaim_final),
		.reclaim_idle(reclaim_idle), .grant_ch(grant_ch));
	lbrg_master_end #(.USE_LOW(1'b0)) lbrg_master_end_inst (.clk(clk), .sys_rst(sys_rst),
		.link(link), .want_bus(want_bus), .has_bus(has_bus), .busy(busy));
	lbrg_link_asserts lbrg_link_asserts_inst (.clk(clk), .sys_rst(sys_rst),
		.cpu_oe0(link.cpu_oe0), .cpu_oe1(link.cpu_oe1), .mst_oe0(link.mst_oe0),
		.mst_oe1(link.mst_oe1), .bus_handoff_line_high_prio(link.bus_handoff_line_high_prio),
		.bus_handoff_line_low_prio(link.bus_handoff_line_low_prio));
	// 25 mhz clock
	initial begin
		forever #20 clk = ~clk;
	end
	// cut a hang short; the run needs a few hundred clocks
	always @(posedge clk) begin
		cyc_count++;
		if (cyc_count == 3000) begin
			fail_count++;
			end_of_test();
		end
	end
	// compare and count
	task check(input logic seen, input logic exp, input string msg);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : check
	// master lets go; reclaim pulse kind follows the pending flag
	task hand_back(input logic pend);
		cycle_pending = pend;
		want_bus = 1'b0;
		for (int i = 0; i < 20 && !(reclaim_final || reclaim_idle); i++) @(negedge clk);
		check(reclaim_final, pend, "reclaim final");
		check(reclaim_idle, !pend, "reclaim idle");
		@(negedge clk);
		check(link.bus_handoff_line_high_prio, 1'b1, "line rests in gap");
		for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk);
		repeat (2) @(negedge clk);
	endtask : hand_back
	// one table row: request, judge the grant, then wait until the master owns the bus
	task run_row(input lbrg_row_t r);
		cur_cycle = r.cyc;
		cur_bstate = r.bs;
		odd_low_byte = r.odd;
		lock_active = r.lck;
		want_bus = 1'b1;
		repeat (12) @(negedge clk);
		check(has_bus, r.ok, "release decision");
		cur_cycle = lbrg_pkg::LBRG_CYC_NONE;
		cur_bstate = lbrg_pkg::LBRG_BS_IDLE;
		odd_low_byte = 1'b0;
		lock_active = 1'b0;
		for (int i = 0; i < 20 && has_bus !== 1'b1; i++) @(negedge clk);
		check(bus_float, 1'b1, "bus floated");
		check(cycle_start_ok, 1'b0, "no cycle in grant");
		check(grant_ch, 1'b0, "high channel served");
	endtask : run_row
	// verdict
	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test
	// main sequence
	initial begin
		repeat (12) @(negedge clk);
		sys_rst = 1'b0;
		check(bus_float, 1'b0, "float after reset");
		check(cycle_start_ok, 1'b1, "start after reset");
		check(link.bus_handoff_line_high_prio, 1'b1, "line rest");
		foreach (rows[i]) begin
			run_row(rows[i]);
			hand_back(1'b0);
		end
		// back-to-back exchange with a cycle waiting at reclaim
		run_row(rows[1]);
		hand_back(1'b1);
		// reset in the middle of a hold: both ends drop the exchange
		run_row(rows[0]);
		sys_rst = 1'b1;
		want_bus = 1'b0;
		repeat (2) @(negedge clk);
		check(bus_float, 1'b0, "float in reset");
		check(has_bus, 1'b0, "master dropped in reset");
		sys_rst = 1'b0;
		@(negedge clk);
		check(cycle_start_ok, 1'b1, "start after mid reset");
		check(link.bus_handoff_line_high_prio, 1'b1, "line rest after reset");
		run_row(rows[0]);
		hand_back(1'b0);
		end_of_test();
	end
endmodule : local_bus_request_grant_test
`default_nettype wire
